//--- rtl/dpcu_param_chan.sv
// dpcu_param_chan.sv: cyclic parameter request/response handler
// assumes: request arrives once per bus cycle on req_valid; table answers on ans.done
`timescale 1ns/10ps
`include "dpcu_params.svh"
module dpcu_param_chan (
    input wire logic clk,
    input wire logic rstn,
    input wire logic req_valid,
    input wire dpcu_pkg::dpcu_chan_t req,
    output dpcu_pkg::dpcu_chan_t resp,
    output dpcu_pkg::dpcu_preq_t tab_req,
    input wire dpcu_pkg::dpcu_pans_t tab_ans
);
    typedef struct packed {
        dpcu_pkg::dpcu_pstate_t st;
        dpcu_pkg::dpcu_chan_t held;
        dpcu_pkg::dpcu_chan_t resp;
        dpcu_pkg::dpcu_preq_t treq;
    } dpcu_pch_t;
    dpcu_pch_t s_q;
    dpcu_pch_t s_d;
    logic [3:0] rq;
    logic known;
    logic arr;
    logic wr;
    logic [3:0] ok_code;

    assign rq = req.param_ident_word[`DPCU_ID_TYPE_HI:`DPCU_ID_TYPE_LO];

    always_comb begin
        known = 1'b1;
        arr = 1'b0;
        wr = 1'b0;
        case (rq)
            `DPCU_RQ_READ: ;
            `DPCU_RQ_WR_W, `DPCU_RQ_WR_D: wr = 1'b1;
            `DPCU_RQ_RD_ARR, `DPCU_RQ_ARR_CNT: arr = 1'b1;
            `DPCU_RQ_WR_ARR_W, `DPCU_RQ_WR_ARR_D: begin
                arr = 1'b1;
                wr = 1'b1;
            end
            default: known = 1'b0;
        endcase
    end

    always_comb begin
        if (s_q.treq.count) begin
            ok_code = `DPCU_RS_COUNT;
        end else if (s_q.treq.is_array) begin
            ok_code = tab_ans.dword ? `DPCU_RS_ARR_D : `DPCU_RS_ARR_W;
        end else begin
            ok_code = tab_ans.dword ? `DPCU_RS_DWORD : `DPCU_RS_WORD;
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.treq.valid = 1'b0;
        case (s_q.st)
            dpcu_pkg::DPCU_IDLE: begin
                if (req_valid && rq != `DPCU_RQ_NONE) begin
                    s_d.held = req;
                    if (!known || req.param_ident_word[`DPCU_ID_SPARE]) begin
                        s_d.resp.param_ident_word = {`DPCU_RS_ERROR, 1'b0,
                            req.param_ident_word[`DPCU_ID_PNUM_HI:0]};
                        s_d.resp.array_subindex = req.array_subindex;
                        s_d.resp.param_value_field = `DPCU_ER_OTHER;
                        s_d.st = dpcu_pkg::DPCU_HOLD;
                    end else begin
                        s_d.treq.valid = 1'b1;
                        s_d.treq.write = wr;
                        s_d.treq.is_array = arr;
                        s_d.treq.count = (rq == `DPCU_RQ_ARR_CNT);
                        s_d.treq.dword = (rq == `DPCU_RQ_WR_D) || (rq == `DPCU_RQ_WR_ARR_D);
                        s_d.treq.param_number = req.param_ident_word[`DPCU_ID_PNUM_HI:0];
                        s_d.treq.array_subindex = req.array_subindex;
                        s_d.treq.value = req.param_value_field;
                        s_d.st = dpcu_pkg::DPCU_WAIT;
                    end
                end
            end
            dpcu_pkg::DPCU_WAIT: begin
                if (tab_ans.done) begin
                    // identifier layout, spare sent as zero
                    s_d.resp.param_ident_word = {tab_ans.err ? `DPCU_RS_ERROR : ok_code,
                        1'b0, s_q.treq.param_number};
                    s_d.resp.array_subindex = s_q.treq.array_subindex;
                    // write echoes value; read value taken now
                    s_d.resp.param_value_field = tab_ans.value;
                    s_d.st = dpcu_pkg::DPCU_HOLD;
                end
            end
            dpcu_pkg::DPCU_HOLD: begin
                if (req_valid && req != s_q.held) begin
                    s_d.resp = '0;
                    s_d.st = dpcu_pkg::DPCU_ZERO;
                end
            end
            dpcu_pkg::DPCU_ZERO: begin
                s_d.resp = '0;
                s_d.st = dpcu_pkg::DPCU_IDLE;
            end
            default: s_d.st = dpcu_pkg::DPCU_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.st <= dpcu_pkg::DPCU_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign resp = s_q.resp;
    assign tab_req = s_q.treq;
endmodule : dpcu_param_chan

//--- rtl/dpcu_params.svh
// dpcu_params.svh: bit positions, codes and reset values of the process-data command unit
// assumes: included by bare name from rtl files
`ifndef DPCU_PARAMS_SVH
`define DPCU_PARAMS_SVH

// control word bits
`define DPCU_CW_RELEASE 4
`define DPCU_CW_KEY_JOG 5
`define DPCU_CW_NO_LOOP 6
`define DPCU_CW_SW_LOOP 7
`define DPCU_CW_JOG_UP 8
`define DPCU_CW_JOG_DN 9
`define DPCU_CW_ACK 14
`define DPCU_CW_RESERVED_MASK 16'hBC00

// status bits
`define DPCU_ST_SUPPLY_OK 4
`define DPCU_ST_ABORTED 5
`define DPCU_ST_BLOCK 10
`define DPCU_ST_DISPLACED 11
`define DPCU_ST_BAD_TARGET 12
`define DPCU_ST_MOTOR_OK 13

// identifier word layout
`define DPCU_ID_TYPE_HI 15
`define DPCU_ID_TYPE_LO 12
`define DPCU_ID_SPARE 11
`define DPCU_ID_PNUM_HI 10

// request codes
`define DPCU_RQ_NONE 4'h0
`define DPCU_RQ_READ 4'h1
`define DPCU_RQ_WR_W 4'h2
`define DPCU_RQ_WR_D 4'h3
`define DPCU_RQ_RD_ARR 4'h6
`define DPCU_RQ_WR_ARR_W 4'h7
`define DPCU_RQ_WR_ARR_D 4'h8
`define DPCU_RQ_ARR_CNT 4'h9

// response codes
`define DPCU_RS_NONE 4'h0
`define DPCU_RS_WORD 4'h1
`define DPCU_RS_DWORD 4'h2
`define DPCU_RS_ARR_W 4'h4
`define DPCU_RS_ARR_D 4'h5
`define DPCU_RS_COUNT 4'h6
`define DPCU_RS_ERROR 4'h7

// error codes
`define DPCU_ER_BAD_PNUM 32'h0000_0000
`define DPCU_ER_READ_ONLY 32'h0000_0001
`define DPCU_ER_LIMIT 32'h0000_0002
`define DPCU_ER_SUBINDEX 32'h0000_0003
`define DPCU_ER_NOT_ARRAY 32'h0000_0004
`define DPCU_ER_WRONG_TYPE 32'h0000_0005
`define DPCU_ER_RESET_ONLY 32'h0000_0006
`define DPCU_ER_OP_STATE 32'h0000_0011
`define DPCU_ER_OTHER 32'h0000_0012

`define DPCU_CW_RESET 16'h0000
`define DPCU_ST_RESET 16'h0000

`endif

//--- rtl/dpcu_pkg.sv
// dpcu_pkg.sv: types shared by the process-data command unit
// assumes: constants come from dpcu_params.svh
package dpcu_pkg;

    // eight-byte parameter channel
    typedef struct packed {
        logic [15:0] param_ident_word;
        logic [15:0] array_subindex;
        logic [31:0] param_value_field;
    } dpcu_chan_t;

    // parameter table access port
    typedef struct packed {
        logic valid;
        logic write;
        logic is_array;
        logic count;
        logic dword;
        logic [10:0] param_number;
        logic [15:0] array_subindex;
        logic [31:0] value;
    } dpcu_preq_t;

    typedef struct packed {
        logic done;
        logic err;
        logic dword;
        logic [31:0] value;
    } dpcu_pans_t;

    typedef enum logic [3:0] {
        DPCU_IDLE = 4'h1,
        DPCU_WAIT = 4'h2,
        DPCU_HOLD = 4'h4,
        DPCU_ZERO = 4'h8
    } dpcu_pstate_t;

    typedef enum logic [2:0] {
        DPCU_RUN_IDLE = 3'h1,
        DPCU_RUN_MOVE = 3'h2,
        DPCU_RUN_SWLOOP = 3'h4
    } dpcu_rstate_t;

endpackage : dpcu_pkg

//--- rtl/dpcu_sync.sv
// dpcu_sync.sv: two-flop synchroniser for one asynchronous level
// assumes: clk is the unit clock, d comes from a pin
`timescale 1ns/10ps
module dpcu_sync (
    input wire logic clk,
    input wire logic rstn,
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic s1;
        logic s2;
    } dpcu_sync_t;
    dpcu_sync_t st_q;
    dpcu_sync_t st_d;

    always_comb begin
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.s2;
endmodule : dpcu_sync

//--- rtl/dpcu_top.sv
// dpcu_top.sv: control-word decoder and parameter channel of a positioning drive
// assumes: process data from a same-clock fieldbus core; motion core and parameter
// table sit outside; supply_ok and motor_ok are pins
`timescale 1ns/10ps
`include "dpcu_params.svh"
module dpcu_top (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cw_valid,
    input wire logic [15:0] control_word,
    input wire logic pos_cmd,
    input wire logic blocked,
    input wire logic displaced,
    input wire logic bad_target,
    input wire logic motion_done,
    input wire logic moving,
    input wire logic bus_active,
    input wire logic key_fwd,
    input wire logic key_bwd,
    input wire logic supply_ok_pin,
    input wire logic motor_ok_pin,
    output logic run_start,
    output logic run_abort,
    output logic no_loop,
    output logic swloop_start,
    output logic jog_fwd,
    output logic jog_bwd,
    output logic cw_reserved_err,
    output logic [15:0] status_bits,
    input wire logic pch_valid,
    input wire dpcu_pkg::dpcu_chan_t pch_req,
    output dpcu_pkg::dpcu_chan_t pch_resp,
    output dpcu_pkg::dpcu_preq_t tab_req,
    input wire dpcu_pkg::dpcu_pans_t tab_ans
);
    typedef struct packed {
        dpcu_pkg::dpcu_rstate_t run;
        logic [15:0] cw;
        logic [15:0] loop_cw;
        logic ack_seen_high;
        logic supply_latched_low;
        logic motor_latched_low;
        logic aborted;
        logic blk;
        logic disp;
        logic badt;
        logic run_start;
        logic run_abort;
        logic swloop_start;
        logic jog_fwd;
        logic jog_bwd;
        logic no_loop;
        logic rsv_err;
        logic [15:0] status;
    } dpcu_top_t;
    dpcu_top_t s_q;
    dpcu_top_t s_d;
    logic supply_ok;
    logic motor_ok;
    logic [15:0] cw_eff;
    logic rel;
    logic ack;
    logic ack_rise;
    logic ack_fall;
    logic run_cmd;
    logic active;

    // -------------------------------------------
    // pin synchronisers
    // -------------------------------------------
    dpcu_sync u_sync_supply (
        .clk(clk),
        .rstn(rstn),
        .d(supply_ok_pin),
        .q(supply_ok)
    );
    dpcu_sync u_sync_motor (
        .clk(clk),
        .rstn(rstn),
        .d(motor_ok_pin),
        .q(motor_ok)
    );

    // -------------------------------------------
    // control word
    // -------------------------------------------
    assign cw_eff = cw_valid ? control_word : s_q.cw;
    assign rel = cw_eff[`DPCU_CW_RELEASE];
    assign ack = cw_eff[`DPCU_CW_ACK];
    assign ack_rise = ack && !s_q.cw[`DPCU_CW_ACK];
    assign ack_fall = !ack && s_q.cw[`DPCU_CW_ACK];
    // new run command: positioning request or fresh jog with release
    assign run_cmd = rel && (pos_cmd
        || (cw_eff[`DPCU_CW_JOG_UP] && !s_q.cw[`DPCU_CW_JOG_UP])
        || (cw_eff[`DPCU_CW_JOG_DN] && !s_q.cw[`DPCU_CW_JOG_DN]));
    assign active = moving || s_q.run != dpcu_pkg::DPCU_RUN_IDLE || run_cmd;

    always_comb begin
        s_d = s_q;
        s_d.cw = cw_eff;
        s_d.run_start = 1'b0;
        s_d.run_abort = 1'b0;
        s_d.swloop_start = 1'b0;
        // reserved bits flagged, not acted on
        s_d.rsv_err = |(cw_eff & `DPCU_CW_RESERVED_MASK);
        s_d.no_loop = cw_eff[`DPCU_CW_NO_LOOP];
        // key jog with enable and no release while bus active; keys jog directly when bus inactive
        // bus jog bits mirror keys, need release
        s_d.jog_fwd = (bus_active && cw_eff[`DPCU_CW_KEY_JOG] && !rel && key_fwd)
            || (!bus_active && key_fwd)
            || (rel && !cw_eff[`DPCU_CW_KEY_JOG] && cw_eff[`DPCU_CW_JOG_UP]);
        s_d.jog_bwd = (bus_active && cw_eff[`DPCU_CW_KEY_JOG] && !rel && key_bwd)
            || (!bus_active && key_bwd)
            || (rel && !cw_eff[`DPCU_CW_KEY_JOG] && cw_eff[`DPCU_CW_JOG_DN]);
        case (s_q.run)
            dpcu_pkg::DPCU_RUN_IDLE: begin
                if (cw_eff[`DPCU_CW_SW_LOOP] && !s_q.cw[`DPCU_CW_SW_LOOP]) begin
                    s_d.swloop_start = 1'b1;
                    s_d.loop_cw = cw_eff;
                    s_d.run = dpcu_pkg::DPCU_RUN_SWLOOP;
                end else if (pos_cmd && rel) begin
                    s_d.run_start = 1'b1;
                    s_d.run = dpcu_pkg::DPCU_RUN_MOVE;
                end
            end
            dpcu_pkg::DPCU_RUN_MOVE: begin
                if (!rel) begin
                    s_d.run_abort = 1'b1;
                    s_d.aborted = 1'b1;
                    s_d.run = dpcu_pkg::DPCU_RUN_IDLE;
                end else if (motion_done) begin
                    s_d.run = dpcu_pkg::DPCU_RUN_IDLE;
                end
            end
            dpcu_pkg::DPCU_RUN_SWLOOP: begin
                if (cw_eff != s_q.loop_cw) begin
                    s_d.run_abort = 1'b1;
                    s_d.aborted = 1'b1;
                    s_d.run = dpcu_pkg::DPCU_RUN_IDLE;
                end else begin
                    s_d.jog_fwd = 1'b0;
                    s_d.jog_bwd = 1'b0;
                    s_d.no_loop = s_q.no_loop;
                    if (motion_done) s_d.run = dpcu_pkg::DPCU_RUN_IDLE;
                end
            end
            default: s_d.run = dpcu_pkg::DPCU_RUN_IDLE;
        endcase

        // ack rise or new run clears flags
        if (run_cmd || ack_rise) begin
            s_d.aborted = s_d.run_abort;
            s_d.blk = 1'b0;
            s_d.disp = 1'b0;
            s_d.badt = 1'b0;
        end
        // set wins over clear
        if (blocked) s_d.blk = 1'b1;
        if (displaced) s_d.disp = 1'b1;
        if (bad_target) s_d.badt = 1'b1;

        if (ack_rise) s_d.ack_seen_high = 1'b1;
        if (ack_fall && s_q.ack_seen_high) begin
            s_d.ack_seen_high = 1'b0;
            s_d.supply_latched_low = 1'b0;
            s_d.motor_latched_low = 1'b0;
        end
        if (run_cmd && supply_ok) s_d.supply_latched_low = 1'b0;
        if (run_cmd && motor_ok) s_d.motor_latched_low = 1'b0;
        // latch failure while active, ack low
        if (!ack && active && !supply_ok) s_d.supply_latched_low = 1'b1;
        if (!ack && active && !motor_ok) s_d.motor_latched_low = 1'b1;
        if (ack) begin
            s_d.supply_latched_low = 1'b0;
            s_d.motor_latched_low = 1'b0;
        end

        s_d.status = `DPCU_ST_RESET;
        s_d.status[`DPCU_ST_SUPPLY_OK] = supply_ok && !s_d.supply_latched_low;
        s_d.status[`DPCU_ST_MOTOR_OK] = motor_ok && !s_d.motor_latched_low;
        s_d.status[`DPCU_ST_ABORTED] = s_d.aborted;
        s_d.status[`DPCU_ST_BLOCK] = s_d.blk;
        s_d.status[`DPCU_ST_DISPLACED] = s_d.disp;
        s_d.status[`DPCU_ST_BAD_TARGET] = s_d.badt;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.run <= dpcu_pkg::DPCU_RUN_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign run_start = s_q.run_start;
    assign run_abort = s_q.run_abort;
    assign no_loop = s_q.no_loop;
    assign swloop_start = s_q.swloop_start;
    assign jog_fwd = s_q.jog_fwd;
    assign jog_bwd = s_q.jog_bwd;
    assign cw_reserved_err = s_q.rsv_err;
    assign status_bits = s_q.status;

    // -------------------------------------------
    // parameter channel
    // -------------------------------------------
    // eight-byte channel
    dpcu_param_chan u_pch (
        .clk(clk),
        .rstn(rstn),
        .req_valid(pch_valid),
        .req(pch_req),
        .resp(pch_resp),
        .tab_req(tab_req),
        .tab_ans(tab_ans)
    );
endmodule : dpcu_top

//--- verification/dpcu_tab_model.sv
// dpcu_tab_model.sv: behavioural parameter table behind the command unit
// assumes: one request at a time on tab_req.valid; 16 entries, odd numbers are dwords
`timescale 1ns/10ps
module dpcu_tab_model (
    input wire logic clk,
    input wire logic rstn,
    input wire dpcu_pkg::dpcu_preq_t tab_req,
    output dpcu_pkg::dpcu_pans_t tab_ans
);
    // ------
    // table
    // ------
    logic [31:0] mem [0:15];
    dpcu_pkg::dpcu_preq_t held;
    int wait_n;
    always @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < 16; i++) mem[i] <= 32'hA500_0000 | 32'(i);
            wait_n <= 0;
            tab_ans <= '0;
        end else begin
            tab_ans.done <= 1'b0;
            // value not held between answers
            tab_ans.value <= ~tab_ans.value;
            if (tab_req.valid) begin
                held <= tab_req;
                // bit 1 of the number picks a slow answer
                wait_n <= tab_req.param_number[1] ? 4 : 1;
            end else if (wait_n > 1) begin
                wait_n <= wait_n - 1;
            end else if (wait_n == 1) begin
                wait_n <= 0;
                tab_ans.done <= 1'b1;
                tab_ans.err <= 1'b0;
                tab_ans.dword <= held.param_number[0];
                if (held.param_number > 11'h00F) begin
                    tab_ans.err <= 1'b1;
                    tab_ans.value <= 32'h0000_0000;
                end else if (held.write && held.param_number == 11'h000) begin
                    tab_ans.err <= 1'b1;
                    tab_ans.value <= 32'h0000_0001;
                end else if (held.count) begin
                    tab_ans.value <= 32'h0000_0008;
                end else if (held.write) begin
                    mem[held.param_number[3:0]] <= held.value;
                    tab_ans.value <= held.value;
                end else begin
                    tab_ans.value <= mem[held.param_number[3:0]];
                end
            end
        end
    end
endmodule : dpcu_tab_model

//--- verification/dpcu_top_props.sv
// dpcu_top_props.sv: port assertions for dpcu_top
// assumes: bound to dpcu_top, one clock, sync active-low reset
`timescale 1ns/10ps
`include "dpcu_params.svh"
module dpcu_top_props (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cw_valid,
    input wire logic [15:0] control_word,
    input wire logic pos_cmd,
    input wire logic blocked,
    input wire logic displaced,
    input wire logic bad_target,
    input wire logic key_fwd,
    input wire logic key_bwd,
    input wire logic supply_ok_pin,
    input wire logic motor_ok_pin,
    input wire logic run_start,
    input wire logic run_abort,
    input wire logic no_loop,
    input wire logic jog_fwd,
    input wire logic jog_bwd,
    input wire logic cw_reserved_err,
    input wire logic [15:0] status_bits,
    input wire dpcu_pkg::dpcu_chan_t pch_resp,
    input wire dpcu_pkg::dpcu_preq_t tab_req,
    input wire dpcu_pkg::dpcu_pans_t tab_ans
);
    // ------
    // properties
    // ------
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_start_release: assert property (
        pos_cmd && cw_valid && !control_word[`DPCU_CW_RELEASE] |=> !run_start)
        else $error("run started without release");
    a_abort_flag: assert property (
        run_abort && $past(cw_valid && !control_word[`DPCU_CW_RELEASE])
        |-> ##[0:1] status_bits[`DPCU_ST_ABORTED]) else $error("abort flag missing");
    a_zero_word: assert property (
        cw_valid && control_word == 16'h0000 && !key_fwd && !key_bwd
        |=> !no_loop && !jog_fwd && !jog_bwd) else $error("zero word not obeyed");
    a_reserved_flag: assert property (
        cw_valid |=> cw_reserved_err == $past(|(control_word & `DPCU_CW_RESERVED_MASK)))
        else $error("reserved flag wrong");
    a_ack_clear: assert property (
        cw_valid && control_word[`DPCU_CW_ACK] && $past(cw_valid && !control_word[`DPCU_CW_ACK])
        && !blocked && !displaced && !bad_target |=> status_bits[12:10] == 3'h0)
        else $error("ack rise did not clear flags");
    a_supply_live: assert property (
        (cw_valid && control_word[`DPCU_CW_ACK] && supply_ok_pin && motor_ok_pin)[*5]
        |-> status_bits[`DPCU_ST_SUPPLY_OK] && status_bits[`DPCU_ST_MOTOR_OK])
        else $error("live supply bits wrong");
    a_supply_fail: assert property (
        (!supply_ok_pin)[*4] |-> !status_bits[`DPCU_ST_SUPPLY_OK])
        else $error("supply bit high on failure");
    a_one_request: assert property (
        tab_req.valid |=> !tab_req.valid [*2]) else $error("second table request too soon");
    a_error_value: assert property (
        tab_ans.done && tab_ans.err |=> pch_resp.param_ident_word[15:12] == `DPCU_RS_ERROR
        && pch_resp.param_value_field == $past(tab_ans.value)) else $error("error answer wrong");
    a_good_answer: assert property (
        tab_ans.done && !tab_ans.err |=> pch_resp.param_ident_word[15:12] inside
        {`DPCU_RS_WORD, `DPCU_RS_DWORD, `DPCU_RS_ARR_W, `DPCU_RS_ARR_D, `DPCU_RS_COUNT})
        else $error("answer code wrong");
endmodule : dpcu_top_props

bind dpcu_top dpcu_top_props u_props (.clk(clk), .rstn(rstn), .cw_valid(cw_valid),
    .control_word(control_word), .pos_cmd(pos_cmd), .blocked(blocked),
    .displaced(displaced), .bad_target(bad_target), .key_fwd(key_fwd), .key_bwd(key_bwd),
    .supply_ok_pin(supply_ok_pin), .motor_ok_pin(motor_ok_pin), .run_start(run_start),
    .run_abort(run_abort), .no_loop(no_loop), .jog_fwd(jog_fwd), .jog_bwd(jog_bwd),
    .cw_reserved_err(cw_reserved_err), .status_bits(status_bits), .pch_resp(pch_resp),
    .tab_req(tab_req), .tab_ans(tab_ans));

//--- verification/dpcu_top_tb_top.sv
// dpcu_top_tb_top.sv: self-checking bench for dpcu_top
// assumes: dpcu_tab_model serves the table port; checker is bound to the dut
`timescale 1ns/10ps
module dpcu_top_tb_top;
    typedef struct packed {
        logic [63:0] req;
        logic [3:0] rs;
        logic [31:0] rv;
    } dpcu_row_t;
    logic clk, rstn, cw_valid, pos_cmd, blocked, displaced, bad_target, motion_done;
    logic moving, bus_active, key_fwd, key_bwd, supply_ok_pin, motor_ok_pin, pch_valid;
    logic run_start, run_abort, no_loop, swloop_start, jog_fwd, jog_bwd, cw_reserved_err;
    logic [15:0] control_word, status_bits;
    dpcu_pkg::dpcu_chan_t pch_req, pch_resp;
    dpcu_pkg::dpcu_preq_t tab_req;
    dpcu_pkg::dpcu_pans_t tab_ans;
    int failures = 0;
    int cmp_count = 0;
    // ------
    // request rows: request, answer code, answer value
    // ------
    dpcu_row_t rows [12] = '{
        '{64'h1005_0000_0000_0000, 4'h2, 32'hA500_0005},
        '{64'h2004_0000_0000_1234, 4'h1, 32'h0000_1234},
        '{64'h1004_0000_0000_0000, 4'h1, 32'h0000_1234},
        '{64'h3007_0000_DEAD_BEEF, 4'h2, 32'hDEAD_BEEF},
        '{64'h6002_0003_0000_0000, 4'h4, 32'hA500_0002},
        '{64'h7002_0001_0000_0055, 4'h4, 32'h0000_0055},
        '{64'h8003_0001_0BAD_F00D, 4'h5, 32'h0BAD_F00D},
        '{64'h9006_0000_0000_0000, 4'h6, 32'h0000_0008},
        '{64'h1014_0000_0000_0000, 4'h7, 32'h0000_0000},
        '{64'h2000_0000_0000_0001, 4'h7, 32'h0000_0001},
        '{64'h5001_0000_0000_0000, 4'h7, 32'h0000_0012},
        '{64'h1805_0000_0000_0000, 4'h7, 32'h0000_0012}};

    dpcu_top dut (.clk(clk), .rstn(rstn), .cw_valid(cw_valid), .control_word(control_word),
        .pos_cmd(pos_cmd), .blocked(blocked), .displaced(displaced), .bad_target(bad_target),
        .motion_done(motion_done), .moving(moving), .bus_active(bus_active),
        .key_fwd(key_fwd), .key_bwd(key_bwd), .supply_ok_pin(supply_ok_pin),
        .motor_ok_pin(motor_ok_pin), .run_start(run_start), .run_abort(run_abort),
        .no_loop(no_loop), .swloop_start(swloop_start), .jog_fwd(jog_fwd), .jog_bwd(jog_bwd),
        .cw_reserved_err(cw_reserved_err), .status_bits(status_bits), .pch_valid(pch_valid),
        .pch_req(pch_req), .pch_resp(pch_resp), .tab_req(tab_req), .tab_ans(tab_ans));
    dpcu_tab_model u_tab (.clk(clk), .rstn(rstn), .tab_req(tab_req), .tab_ans(tab_ans));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic cw(input logic [15:0] w, input int n);
        control_word = w;
        cyc(n);
    endtask : cw
    task automatic start_run;
        control_word = 16'h0010;
        pos_cmd = 1'b1;
        cyc(1);
        pos_cmd = 1'b0;
    endtask : start_run
    // request repeated until answered, then no-request until idle
    task automatic run_row(input dpcu_row_t r);
        int n;
        n = 0;
        pch_req = r.req;
        while (pch_resp.param_ident_word[15:12] === 4'h0 && n < 30) begin
            cyc(1);
            n++;
        end
        cyc(1);
        chk("resp type", 32'(r.rs), 32'(pch_resp.param_ident_word[15:12]));
        chk("resp index", 32'(r.req[47:32]), 32'(pch_resp.array_subindex));
        chk("resp value", r.rv, pch_resp.param_value_field);
        if (r.rs != 4'h7) chk("resp pnum", 32'(r.req[58:48]), 32'(pch_resp[58:48]));
        pch_req = '0;
        n = 0;
        while (pch_resp.param_ident_word[15:12] !== 4'h0 && n < 30) begin
            cyc(1);
            n++;
        end
        chk("resp idle", 32'h0, 32'(pch_resp.param_ident_word));
    endtask : run_row
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    initial begin
        // whole run is well under 1500 cycles
        #(8 * 4000);
        failures++;
        $display("[FAIL] watchdog expected end seen hang");
        conclude();
    end

    initial begin
        {rstn, pos_cmd, blocked, displaced, bad_target, motion_done, moving} = 7'h00;
        {key_fwd, key_bwd, pch_valid, cw_valid, bus_active, supply_ok_pin, motor_ok_pin} = 7'h1F;
        control_word = 16'h0000;
        pch_req = '0;
        cyc(6);
        chk("reset status", 32'h0, 32'(status_bits));
        rstn = 1'b1;
        cyc(1);
        foreach (rows[i]) run_row(rows[i]);
        $display("test parameter rows done");
        pos_cmd = 1'b1;
        cyc(1);
        pos_cmd = 1'b0;
        chk("start no release", 32'h0, 32'(run_start));
        start_run();
        chk("start", 32'h1, 32'(run_start));
        motion_done = 1'b1;
        cyc(1);
        motion_done = 1'b0;
        cw(16'h0000, 1);
        chk("abort when idle", 32'h0, 32'(run_abort));
        start_run();
        moving = 1'b1;
        cw(16'h0000, 1);
        chk("abort", 32'h1, 32'(run_abort));
        cyc(1);
        chk("aborted flag", 32'h1, 32'(status_bits[5]));
        moving = 1'b0;
        {blocked, displaced, bad_target} = 3'h7;
        cyc(1);
        {blocked, displaced, bad_target} = 3'h0;
        cyc(1);
        chk("event flags", 32'h7, 32'(status_bits[12:10]));
        cw(16'h4000, 2);
        chk("ack clears", 32'h0, 32'({status_bits[12:10], status_bits[5]}));
        $display("test run gate done");
        cw(16'h0000, 1);
        moving = 1'b1;
        {supply_ok_pin, motor_ok_pin} = 2'h0;
        cyc(4);
        {supply_ok_pin, motor_ok_pin} = 2'h3;
        cyc(5);
        chk("latched", 32'h0, 32'({status_bits[13], status_bits[4]}));
        cw(16'h4000, 2);
        chk("live", 32'h3, 32'({status_bits[13], status_bits[4]}));
        cw(16'h0000, 2);
        chk("unlatched", 32'h3, 32'({status_bits[13], status_bits[4]}));
        moving = 1'b0;
        $display("test supply latch done");
        cw(16'h0080, 1);
        chk("loop start", 32'h1, 32'(swloop_start));
        cyc(1);
        chk("loop kept", 32'h0, 32'(run_abort));
        cw(16'h0000, 1);
        chk("loop abort", 32'h1, 32'(run_abort));
        cw(16'h0110, 1);
        chk("bus jog up", 32'h1, 32'(jog_fwd));
        cw(16'h0210, 1);
        chk("bus jog down", 32'h1, 32'(jog_bwd));
        cw(16'h0130, 1);
        chk("bus jog blocked", 32'h0, 32'(jog_fwd));
        {key_fwd, key_bwd} = 2'h3;
        cw(16'h0020, 1);
        chk("key jog", 32'h3, 32'({jog_fwd, jog_bwd}));
        cw(16'h0030, 1);
        chk("key jog refused", 32'h0, 32'({jog_fwd, jog_bwd}));
        {key_fwd, key_bwd} = 2'h0;
        $display("test loop and jog done");
        cw(16'h0040, 1);
        chk("no loop", 32'h1, 32'(no_loop));
        cw_valid = 1'b0;
        cw(16'h0000, 2);
        chk("word held", 32'h1, 32'(no_loop));
        cw_valid = 1'b1;
        for (int i = 10; i < 16; i++) begin
            if (i != 14) begin
                cw(16'h0001 << i, 1);
                chk("reserved bit", 32'h1, 32'(cw_reserved_err));
            end
        end
        rstn = 1'b0;
        cyc(3);
        chk("mid reset", 32'h0, 32'({status_bits, pch_resp.param_ident_word}));
        rstn = 1'b1;
        cyc(2);
        $display("test control bits and reset done");
        conclude();
    end
endmodule : dpcu_top_tb_top
